// [include/sslc_pkg.sv]
// Constants shared by the switch shift and latch control block
package sslc_pkg;

  // Shift register and latch width
  localparam int SSLC_WIDTH = 16;

  // Synchroniser depth for pin inputs
  localparam int SSLC_SYNC_STAGES = 2;

  // Pin synchroniser bit positions
  localparam int SSLC_PIN_SCLK = 0;
  localparam int SSLC_PIN_DIN = 1;
  localparam int SSLC_PIN_LOAD_N = 2;
  localparam int SSLC_PIN_CLEAR = 3;
  localparam int SSLC_PIN_SET = 4;
  localparam int SSLC_PIN_COUNT = 5;

  // Reset values
  localparam logic [SSLC_WIDTH-1:0] SSLC_SHIFT_RESET = 16'h0000;
  localparam logic [SSLC_WIDTH-1:0] SSLC_LATCH_RESET = 16'h0000;
  localparam logic SSLC_DOUT_RESET = 1'h0;

  // Latch update sources
  typedef enum logic [1:0] {
    SSLC_LATCH_HOLD,
    SSLC_LATCH_FOLLOW,
    SSLC_LATCH_FORCE_CLEAR,
    SSLC_LATCH_FORCE_SET
  } sslc_latch_op_e;

endpackage : sslc_pkg

// [rtl/sslc_sync.sv]
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none

module sslc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin side
  input wire logic [WIDTH-1:0] async_in,
  // Clock domain side
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  if (WIDTH < 1) begin : g_width_check
    $error("sslc_sync: WIDTH must be at least 1");
  end

  // First stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule : sslc_sync

`default_nettype wire

// [rtl/sslc_top.sv]
// Serial shift register and switch latch control
`timescale 1ns/1ps
`default_nettype none


module sslc_top
  import sslc_pkg::*;
#(
  parameter int WIDTH = sslc_pkg::SSLC_WIDTH
) (
  // System clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial link pins
  input wire logic ser_clk,
  input wire logic ser_din,
  output logic ser_dout,
  // Latch control pins
  input wire logic latch_load_n,
  input wire logic latch_clear,
  input wire logic latch_set,
  // Switch enables
  output logic [WIDTH-1:0] switch_enable
);

  import sslc_pkg::*;

  if (WIDTH != SSLC_WIDTH) begin : g_width_check
    $error("sslc_top: WIDTH must equal the fixed shift register width");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [SSLC_PIN_COUNT-1:0] pins_async;
  logic [SSLC_PIN_COUNT-1:0] pins_sync;
  logic sclk_s;
  logic din_s;
  logic load_n_s;
  logic clear_s;
  logic set_s;

  always_comb begin
    pins_async = '0;
    pins_async[SSLC_PIN_SCLK] = ser_clk;
    pins_async[SSLC_PIN_DIN] = ser_din;
    pins_async[SSLC_PIN_LOAD_N] = latch_load_n;
    pins_async[SSLC_PIN_CLEAR] = latch_clear;
    pins_async[SSLC_PIN_SET] = latch_set;
  end

  sslc_sync #(
    .WIDTH(SSLC_PIN_COUNT)
  ) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .async_in(pins_async),
    .sync_out(pins_sync)
  );

  assign sclk_s = pins_sync[SSLC_PIN_SCLK];
  assign din_s = pins_sync[SSLC_PIN_DIN];
  assign load_n_s = pins_sync[SSLC_PIN_LOAD_N];
  assign clear_s = pins_sync[SSLC_PIN_CLEAR];
  assign set_s = pins_sync[SSLC_PIN_SET];

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock edge detection

  logic sclk_prev_reg;
  logic sclk_rise;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_prev_reg <= 1'h0;
    end else begin
      sclk_prev_reg <= sclk_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Shift register and serial output

  logic [WIDTH-1:0] shift_reg;
  logic [WIDTH-1:0] shift_next;
  logic dout_reg;

  // MSB first: new bit enters stage 0, oldest leaves stage WIDTH-1
  always_comb begin
    shift_next = {shift_reg[WIDTH-2:0], din_s};
  end

  // Clear and set never touch this register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_reg <= SSLC_SHIFT_RESET;
    end else if (sclk_rise) begin
      shift_reg <= shift_next;
    end
  end

  // Output is the last stage, moved on the same edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dout_reg <= SSLC_DOUT_RESET;
    end else if (sclk_rise) begin
      dout_reg <= shift_next[WIDTH-1];
    end
  end

  assign ser_dout = dout_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Latch control

  sslc_latch_op_e latch_op;
  logic [WIDTH-1:0] latch_reg;

  // Clear dominates set, set dominates load
  always_comb begin
    if (clear_s) begin
      latch_op = SSLC_LATCH_FORCE_CLEAR;
    end else if (set_s) begin
      latch_op = SSLC_LATCH_FORCE_SET;
    end else if (!load_n_s) begin
      latch_op = SSLC_LATCH_FOLLOW;
    end else begin
      latch_op = SSLC_LATCH_HOLD;
    end
  end

  // Forces need no serial clock edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latch_reg <= SSLC_LATCH_RESET;
    end else begin
      unique case (latch_op)
        SSLC_LATCH_FORCE_CLEAR: begin
          latch_reg <= '0;
        end
        SSLC_LATCH_FORCE_SET: begin
          latch_reg <= '1;
        end
        SSLC_LATCH_FOLLOW: begin
          latch_reg <= shift_reg;
        end
        SSLC_LATCH_HOLD: begin
          latch_reg <= latch_reg;
        end
      endcase
    end
  end

  // Bit i drives switch i
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_switch
      assign switch_enable[gi] = latch_reg[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (rst);

  // Delay probe: one marked input bit per sixteen serial clock rises
  logic [3:0] probe_cnt_reg;
  logic probe_bit_reg;
  logic probe_valid_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      probe_cnt_reg <= 4'h0;
      probe_bit_reg <= 1'h0;
      probe_valid_reg <= 1'h0;
    end else if (sclk_rise) begin
      probe_cnt_reg <= probe_cnt_reg + 4'h1;
      if (probe_cnt_reg == 4'h0) begin
        probe_bit_reg <= din_s;
        probe_valid_reg <= 1'h1;
      end
    end
  end

  a_shift_in_msb: assert property (
    sclk_rise |=> (shift_reg[0] == $past(din_s)) && (shift_reg[WIDTH-1:1] == $past(shift_reg[WIDTH-2:0]))
  ) else $error("shift register did not take serial input");

  a_shift_idle_hold: assert property (
    !sclk_rise |=> $stable(shift_reg)
  ) else $error("shift register moved without serial clock edge");

  a_dout_last_stage: assert property (
    ser_dout == shift_reg[WIDTH-1]
  ) else $error("serial output differs from last stage");

  a_dout_edge_only: assert property (
    !sclk_rise |=> $stable(ser_dout)
  ) else $error("serial output changed without serial clock edge");

  a_dout_sixteen_shifts: assert property (
    (sclk_rise && probe_valid_reg && (probe_cnt_reg == 4'(WIDTH - 1))) |=> (ser_dout == probe_bit_reg)
  ) else $error("serial output did not repeat input sixteen rises later");

  a_clear_forces_zero: assert property (
    clear_s |=> (switch_enable == '0)
  ) else $error("clear did not zero the latch");

  a_clear_over_set: assert property (
    (clear_s && set_s) [*2] |-> (switch_enable == '0)
  ) else $error("set won over clear");

  a_set_forces_one: assert property (
    (set_s && !clear_s) |=> (switch_enable == '1)
  ) else $error("set did not fill the latch");

  a_force_keeps_shift: assert property (
    ((clear_s || set_s) && !sclk_rise) |=> $stable(shift_reg)
  ) else $error("clear or set disturbed the shift register");

  a_load_follows: assert property (
    (!load_n_s && !clear_s && !set_s) |=> (switch_enable == $past(shift_reg))
  ) else $error("transparent latch did not follow shift register");

  a_load_high_holds: assert property (
    (load_n_s && !clear_s && !set_s) |=> $stable(switch_enable)
  ) else $error("latch changed while load was high");

  a_restore_after_force: assert property (
    (($fell(set_s) || $fell(clear_s)) && !clear_s && !set_s && !load_n_s) |=> (switch_enable == $past(shift_reg))
  ) else $error("latch not restored after force release");

endmodule : sslc_top

`default_nettype wire

// [tb/sslc_host_model.sv]
// Host controller model for the serial link and latch pins
`timescale 1ns/1ps
`default_nettype none

module sslc_host_model (
  // Serial link
  output logic ser_clk,
  output logic ser_din,
  // Latch control
  output logic latch_load_n,
  output logic latch_clear,
  output logic latch_set
);
  initial begin
    ser_clk = 1'h0;
    ser_din = 1'h1;
    latch_load_n = 1'h1;
    latch_clear = 1'h0;
    latch_set = 1'h0;
  end

  // One bit per 125 ns; clock idles low, data inverted once hold is over
  task automatic send_bit(input logic b);
    ser_din = b;
    #62.5 ser_clk = 1'h1;
    #31 ser_din = ~b;
    #31.5 ser_clk = 1'h0;
  endtask : send_bit

  // Latch load level
  task automatic hold_load(input logic v);
    latch_load_n = v;
    #40;
  endtask : hold_load

  // Load pulse after a full word
  task automatic load_pulse();
    hold_load(1'h0);
    hold_load(1'h1);
  endtask : load_pulse

  // Clear and set levels
  task automatic drive_ctl(input logic clr, input logic st);
    latch_clear = clr;
    latch_set = st;
    #40;
  endtask : drive_ctl
endmodule : sslc_host_model

`default_nettype wire

// [tb/sslc_top_tb.sv]
// Self-checking bench for the switch shift and latch control block
`timescale 1ns/1ps
`default_nettype none

module sslc_top_tb;
  import sslc_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  wire ser_clk, ser_din, ser_dout, latch_load_n, latch_clear, latch_set;
  wire [SSLC_WIDTH-1:0] switch_enable;
  int err_count = 0;
  int cmp_count = 0;
  integer seed = 32'hC6EF;
  logic [SSLC_WIDTH-1:0] shift_m = 16'h0000;
  logic [SSLC_WIDTH-1:0] latch_m = 16'h0000;
  logic [SSLC_WIDTH-1:0] word;
  int din_q[$];

  always #2 clk = ~clk;

  sslc_top #(.WIDTH(SSLC_WIDTH)) u_sslc_top (.clk(clk), .rst(rst), .ser_clk(ser_clk), .ser_din(ser_din),
    .ser_dout(ser_dout), .latch_load_n(latch_load_n), .latch_clear(latch_clear), .latch_set(latch_set),
    .switch_enable(switch_enable));
  sslc_host_model u_sslc_host_model (.ser_clk(ser_clk), .ser_din(ser_din), .latch_load_n(latch_load_n),
    .latch_clear(latch_clear), .latch_set(latch_set));

  task automatic check(input logic [SSLC_WIDTH-1:0] seen, input logic [SSLC_WIDTH-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // Word MSB first, serial output and switches checked after every bit
  task automatic shift_word(input logic [SSLC_WIDTH-1:0] w, input logic follow);
    for (int i = SSLC_WIDTH - 1; i >= 0; i--) begin
      u_sslc_host_model.send_bit(w[i]);
      shift_m = {shift_m[SSLC_WIDTH-2:0], w[i]};
      if (follow) latch_m = shift_m;
      din_q.push_back(int'(w[i]));
      check({15'h0000, ser_dout}, {15'h0000, shift_m[SSLC_WIDTH-1]});
      check({15'h0000, ser_dout},
        (din_q.size() >= SSLC_WIDTH) ? 16'(din_q[din_q.size() - SSLC_WIDTH]) : 16'h0000);
      check(switch_enable, latch_m);
    end
  endtask : shift_word

  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk) rst = 1'h0;
    check(switch_enable, 16'h0000);
    check({15'h0000, ser_dout}, 16'h0000);
    // Host pin edges stay off the clock edges
    #0.25;
    // Shift with load high, then load pulse
    for (int n = 0; n < 4; n++) begin
      word = (n == 0) ? 16'h0001 : (n == 1) ? 16'h8000 : 16'($random(seed));
      shift_word(word, 1'h0);
      u_sslc_host_model.load_pulse();
      latch_m = word;
      check(switch_enable, word);
    end
    // Forced states keep the shift register
    word = 16'($random(seed));
    u_sslc_host_model.drive_ctl(1'h1, 1'h0);
    latch_m = 16'h0000;
    check(switch_enable, 16'h0000);
    shift_word(word, 1'h0);
    u_sslc_host_model.load_pulse();
    check(switch_enable, 16'h0000);
    u_sslc_host_model.drive_ctl(1'h1, 1'h1);
    check(switch_enable, 16'h0000);
    u_sslc_host_model.drive_ctl(1'h0, 1'h1);
    check(switch_enable, 16'hFFFF);
    u_sslc_host_model.load_pulse();
    check(switch_enable, 16'hFFFF);
    u_sslc_host_model.drive_ctl(1'h0, 1'h0);
    check(switch_enable, 16'hFFFF);
    u_sslc_host_model.load_pulse();
    latch_m = word;
    check(switch_enable, word);
    // Clear released while load is low restores the latch
    u_sslc_host_model.drive_ctl(1'h1, 1'h0);
    u_sslc_host_model.hold_load(1'h0);
    check(switch_enable, 16'h0000);
    u_sslc_host_model.drive_ctl(1'h0, 1'h0);
    latch_m = shift_m;
    check(switch_enable, shift_m);
    // Transparent latch while shifting
    shift_word(16'($random(seed)), 1'h1);
    u_sslc_host_model.hold_load(1'h1);
    // Reset in mid-run clears both registers
    @(negedge clk) rst = 1'h1;
    repeat (2) @(negedge clk);
    rst = 1'h0;
    shift_m = 16'h0000;
    latch_m = 16'h0000;
    din_q.delete();
    check(switch_enable, latch_m);
    check({15'h0000, ser_dout}, {15'h0000, shift_m[SSLC_WIDTH-1]});
    end_of_test();
  end

  // Watchdog
  initial begin
    #100000;
    err_count++;
    $display("CHECK FAILED %0t run did not finish", $time);
    end_of_test();
  end
endmodule : sslc_top_tb

`default_nettype wire
